// ### psr_cfg.svh
// Configuration constants for the pad sleep, hold and signal routing block.
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH
`define PSR_PAD_NUM       8
`define PSR_LP_PAD_NUM    4
`define PSR_SIG_NUM       256
`define PSR_AXI_AW        8
`define PSR_SW_OUT_IDX    9'h100
`define PSR_OSEL_MSB      8
`define PSR_OSEL_LSB      0
`define PSR_OINV_BIT      9
`define PSR_OEN_BIT       10
`define PSR_ISEL_MSB      19
`define PSR_ISEL_LSB      12
`define PSR_IEN_BIT       20
`define PSR_DRV_MSB       1
`define PSR_DRV_LSB       0
`define PSR_WPU_BIT       2
`define PSR_WPD_BIT       3
`define PSR_SLP_SEL_BIT   4
`define PSR_SLP_WPU_BIT   5
`define PSR_SLP_WPD_BIT   6
`define PSR_SLP_OE_BIT    7
`define PSR_ROUTE_RST     32'h0000_0100
`define PSR_MUX_RST       32'h0000_0002
`define PSR_BANK_ROUTE    3'h0
`define PSR_BANK_MUX      3'h1
`define PSR_BANK_GLOBAL   3'h2
`define PSR_G_OUT         3'h0
`define PSR_G_ENABLE      3'h1
`define PSR_G_HOLD        3'h2
`define PSR_G_RELEASE     3'h3
`define PSR_G_PAD_IN      3'h4
`define PSR_G_HELD        3'h5
`define PSR_RESP_OKAY     2'h0
`define PSR_RESP_SLVERR   2'h2
`endif

// ### psr_pkg.sv
// Types shared by the pad sleep, hold and signal routing block.
package psr_pkg;
  typedef enum logic [2:0] {
    PSR_SEL_ROUTE  = 3'h0,
    PSR_SEL_MUX    = 3'h1,
    PSR_SEL_GLOBAL = 3'h3,
    PSR_SEL_NONE   = 3'h2
  } psr_sel_t;
endpackage

// ### psr_pad_cell.sv
// Per-pad hold cell that freezes the pad state while hold is asserted.
`timescale 1ns/1ps
`default_nettype none
module psr_pad_cell (
  input  wire logic       clk,         // System clock.
  input  wire logic       por_rst,     // Power-on reset only.
  input  wire logic       hold,        // Freeze request.
  input  wire logic       live_out,    // Live output value.
  input  wire logic       live_oe,     // Live output enable.
  input  wire logic       live_pu,     // Live pull-up.
  input  wire logic       live_pd,     // Live pull-down.
  input  wire logic [1:0] live_drv,    // Live drive strength.
  input  wire logic       live_in,     // Pad input level.
  output logic            pad_out,     // Registered output value.
  output logic            pad_oe,      // Registered output enable.
  output logic            pad_pu,      // Registered pull-up.
  output logic            pad_pd,      // Registered pull-down.
  output logic      [1:0] pad_drv,     // Registered drive strength.
  output logic            pad_in_q     // Registered or frozen input.
);
  // The state is only reset at power-on so that a held pad rides through core resets.
  always_ff @(posedge clk) begin
    if (por_rst) begin
      pad_out  <= 1'b0;
      pad_oe   <= 1'b0;
      pad_pu   <= 1'b0;
      pad_pd   <= 1'b0;
      pad_drv  <= 2'h2;
      pad_in_q <= 1'b0;
    end else if (!hold) begin // R04 R05 R18
      pad_out  <= live_out;
      pad_oe   <= live_oe;
      pad_pu   <= live_pu;
      pad_pd   <= live_pd;
      pad_drv  <= live_drv;
      pad_in_q <= live_in;
    end
  end
endmodule
`default_nettype wire

// ### psr_pad_ctrl.sv
// Pad sleep override, hold and signal routing matrix with an AXI4-Lite register slave.
// Contract
// (R01) Sleep-override select 1 during light sleep switches pad to sleep controls.
// (R02) In sleep override, pulls and output enable use sleep bits; drive stays normal.
// (R03) Sleep-override select 0 keeps normal controls in normal run and light sleep.
// (R04) Every pad has its own hold; held pads ignore signals and routing changes.
// (R05) Held state survives core and system resets.
// (R06) Software writes force-release 0 before power-down to keep digital pads.
// (R07) Writing force-release 1 releases hold on all digital pads.
// (R08) Low-power pad hold bit 1 holds the pad, 0 releases it.
// (R09) Enable source select 1 takes output enable from software enable bit n.
// (R10) Enable source select 0 takes output enable from the selected peripheral.
// (R11) Peripherals with constant enable stay enabled when the select is cleared.
// (R12) Only listed input indices are valid; others are unconnected.
// (R13) Only listed output indices are valid; others drive nothing.
// (R14) Output signal select chooses which peripheral output drives the pad.
// (R15) Output select 256 drives the pad from the software output bit.
// (R16) Output invert select inverts the routed output before the pad.
// (R17) Unrouted peripheral inputs take defaults: data bus clocks high, others low.
// (R18) Hold and force-release live in power-on reset domain only.
`include "psr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module psr_pad_ctrl
  import psr_pkg::*;
(
  input  wire logic                      clk,            // System clock.
  input  wire logic                      srst,           // Core reset, synchronous, active high.
  input  wire logic                      por_rst,        // Power-on reset, synchronous, active high.
  input  wire logic                      light_sleep,    // Chip is in light sleep.
  input  wire logic [`PSR_AXI_AW-1:0]    s_axi_awaddr,   // Write address.
  input  wire logic                      s_axi_awvalid,  // Write address valid.
  output logic                           s_axi_awready,  // Write address ready.
  input  wire logic [31:0]               s_axi_wdata,    // Write data.
  input  wire logic [3:0]                s_axi_wstrb,    // Write byte strobes.
  input  wire logic                      s_axi_wvalid,   // Write data valid.
  output logic                           s_axi_wready,   // Write data ready.
  output logic [1:0]                     s_axi_bresp,    // Write response.
  output logic                           s_axi_bvalid,   // Write response valid.
  input  wire logic                      s_axi_bready,   // Write response ready.
  input  wire logic [`PSR_AXI_AW-1:0]    s_axi_araddr,   // Read address.
  input  wire logic                      s_axi_arvalid,  // Read address valid.
  output logic                           s_axi_arready,  // Read address ready.
  output logic [31:0]                    s_axi_rdata,    // Read data.
  output logic [1:0]                     s_axi_rresp,    // Read response.
  output logic                           s_axi_rvalid,   // Read data valid.
  input  wire logic                      s_axi_rready,   // Read data ready.
  input  wire logic [`PSR_PAD_NUM-1:0]   pad_in,         // Pad input levels.
  input  wire logic [`PSR_SIG_NUM-1:0]   periph_out,     // Peripheral output signals.
  input  wire logic [`PSR_SIG_NUM-1:0]   periph_oe,      // Peripheral output enables.
  output logic      [`PSR_SIG_NUM-1:0]   periph_in,      // Peripheral input signals.
  output logic      [`PSR_PAD_NUM-1:0]   pad_out,        // Pad output values.
  output logic      [`PSR_PAD_NUM-1:0]   pad_oe,         // Pad output enables.
  output logic      [`PSR_PAD_NUM-1:0]   pad_pu,         // Pad pull-up enables.
  output logic      [`PSR_PAD_NUM-1:0]   pad_pd,         // Pad pull-down enables.
  output logic      [2*`PSR_PAD_NUM-1:0] pad_drv         // Pad drive strengths, two bits each.
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  function automatic logic out_valid(input logic [8:0] idx);
    out_valid = (idx <= 9'h020) || (idx == 9'h036) ||
                (idx >= 9'h03c && idx <= 9'h054) ||
                (idx >= 9'h059 && idx <= 9'h0bb) ||
                (idx >= 9'h0d0 && idx <= 9'h0e4); // R13
  endfunction

  function automatic logic in_valid(input logic [7:0] idx);
    in_valid = (idx <= 8'h03) || (idx >= 8'h07 && idx <= 8'h30) ||
               (idx >= 8'h33 && idx <= 8'h36) || (idx >= 8'h3a && idx <= 8'h3e) ||
               (idx >= 8'h42 && idx <= 8'h47) || (idx == 8'h49) ||
               (idx >= 8'h51 && idx <= 8'h54) || (idx >= 8'h59 && idx <= 8'h5c) ||
               (idx >= 8'h65 && idx <= 8'h6e) || (idx == 8'h74) ||
               (idx >= 8'h78 && idx <= 8'h7b) || (idx >= 8'h81 && idx <= 8'h83) ||
               (idx >= 8'h85 && idx <= 8'h98) || (idx >= 8'h9b && idx <= 8'hbb) ||
               (idx >= 8'hc0 && idx <= 8'hc7) || (idx >= 8'hd0 && idx <= 8'he4) ||
               (idx >= 8'hfb); // R12
  endfunction

  function automatic logic oe_const1(input logic [8:0] idx);
    oe_const1 = (idx >= 9'h00c && idx <= 9'h041) ||
                (idx >= 9'h049 && idx <= 9'h058) ||
                (idx >= 9'h05d && idx <= 9'h064) ||
                (idx >= 9'h074 && idx <= 9'h076); // R11
  endfunction

  function automatic logic in_default(input logic [7:0] idx);
    in_default = (idx >= 8'h59 && idx <= 8'h5c) || (idx == 8'h74); // R17
  endfunction

  function automatic psr_sel_t decode(input logic [`PSR_AXI_AW-1:0] addr);
    logic [2:0] bank;
    logic [2:0] idx;
    bank = addr[7:5];
    idx  = addr[4:2];
    if (bank == `PSR_BANK_ROUTE) begin
      decode = PSR_SEL_ROUTE;
    end else if (bank == `PSR_BANK_MUX) begin
      decode = PSR_SEL_MUX;
    end else if (bank == `PSR_BANK_GLOBAL && idx <= `PSR_G_HELD) begin
      decode = PSR_SEL_GLOBAL;
    end else begin
      decode = PSR_SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? wd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [31:0]             route_cfg_ff [`PSR_PAD_NUM];
  logic [31:0]             mux_cfg_ff   [`PSR_PAD_NUM];
  logic [`PSR_PAD_NUM-1:0] sw_out_ff;
  logic [`PSR_PAD_NUM-1:0] sw_en_ff;
  logic [`PSR_PAD_NUM-1:0] hold_bits_ff;
  logic                    force_release_ff;
  logic [`PSR_AXI_AW-1:0]  awaddr_ff;
  logic [31:0]             wdata_ff;
  logic [3:0]              wstrb_ff;
  logic                    wr_go;
  psr_sel_t                wr_sel;
  logic [2:0]              wr_idx;
  logic [`PSR_PAD_NUM-1:0] held;
  logic [`PSR_PAD_NUM-1:0] pad_in_q;

  assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_sel = decode(awaddr_ff);
  assign wr_idx = awaddr_ff[4:2];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel.

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSR_RESP_OKAY;
      awaddr_ff     <= '0;
      wdata_ff      <= '0;
      wstrb_ff      <= '0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        s_axi_awready <= 1'b0;
        awaddr_ff     <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        s_axi_wready <= 1'b0;
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= (wr_sel == PSR_SEL_NONE) ? `PSR_RESP_SLVERR : `PSR_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Core-domain configuration registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int p = 0; p < `PSR_PAD_NUM; p++) begin
        route_cfg_ff[p] <= `PSR_ROUTE_RST;
        mux_cfg_ff[p]   <= `PSR_MUX_RST;
      end
      sw_out_ff <= '0;
      sw_en_ff  <= '0;
    end else if (wr_go) begin
      if (wr_sel == PSR_SEL_ROUTE) begin
        route_cfg_ff[wr_idx] <= merge(route_cfg_ff[wr_idx], wdata_ff, wstrb_ff);
      end else if (wr_sel == PSR_SEL_MUX) begin
        mux_cfg_ff[wr_idx] <= merge(mux_cfg_ff[wr_idx], wdata_ff, wstrb_ff);
      end else if (wr_sel == PSR_SEL_GLOBAL && wr_idx == `PSR_G_OUT && wstrb_ff[0]) begin
        sw_out_ff <= wdata_ff[`PSR_PAD_NUM-1:0];
      end else if (wr_sel == PSR_SEL_GLOBAL && wr_idx == `PSR_G_ENABLE && wstrb_ff[0]) begin
        sw_en_ff <= wdata_ff[`PSR_PAD_NUM-1:0];
      end
    end
  end

  // Hold controls are cleared only at power-on so that they outlive core resets.
  always_ff @(posedge clk) begin
    if (por_rst) begin // R18
      hold_bits_ff     <= '0;
      force_release_ff <= 1'b0;
    end else if (wr_go && wr_sel == PSR_SEL_GLOBAL && wstrb_ff[0]) begin
      if (wr_idx == `PSR_G_HOLD) begin
        hold_bits_ff <= wdata_ff[`PSR_PAD_NUM-1:0]; // R04 R08
      end
      if (wr_idx == `PSR_G_RELEASE) begin
        force_release_ff <= wdata_ff[0]; // R06 R07
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  logic [31:0] rd_word;
  psr_sel_t    rd_sel;
  logic [2:0]  rd_idx;

  assign rd_sel = decode(s_axi_araddr);
  assign rd_idx = s_axi_araddr[4:2];

  always_comb begin
    rd_word = '0;
    case (rd_sel)
      PSR_SEL_ROUTE: rd_word = route_cfg_ff[rd_idx];
      PSR_SEL_MUX:   rd_word = mux_cfg_ff[rd_idx];
      PSR_SEL_GLOBAL: begin
        case (rd_idx)
          `PSR_G_OUT:     rd_word[`PSR_PAD_NUM-1:0] = sw_out_ff;
          `PSR_G_ENABLE:  rd_word[`PSR_PAD_NUM-1:0] = sw_en_ff;
          `PSR_G_HOLD:    rd_word[`PSR_PAD_NUM-1:0] = hold_bits_ff;
          `PSR_G_RELEASE: rd_word[0] = force_release_ff;
          `PSR_G_PAD_IN:  rd_word[`PSR_PAD_NUM-1:0] = pad_in_q;
          `PSR_G_HELD:    rd_word[`PSR_PAD_NUM-1:0] = held;
          default:        rd_word = '0;
        endcase
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `PSR_RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (rd_sel == PSR_SEL_NONE) ? `PSR_RESP_SLVERR : `PSR_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output routing, sleep override and hold per pad.

  logic [`PSR_PAD_NUM-1:0] live_out;
  logic [`PSR_PAD_NUM-1:0] live_oe;
  logic [`PSR_PAD_NUM-1:0] live_pu;
  logic [`PSR_PAD_NUM-1:0] live_pd;

  always_comb begin
    for (int p = 0; p < `PSR_PAD_NUM; p++) begin
      logic [8:0] osel;
      logic       route_val;
      logic       route_oe;
      logic       slp;
      route_val = 1'b0; // R13
      route_oe  = 1'b0;
      osel = route_cfg_ff[p][`PSR_OSEL_MSB:`PSR_OSEL_LSB]; // R14
      if (osel == `PSR_SW_OUT_IDX) begin
        route_val = sw_out_ff[p]; // R15
      end else if (out_valid(osel)) begin
        route_val = periph_out[osel[7:0]]; // R14
      end
      if (route_cfg_ff[p][`PSR_OEN_BIT]) begin
        route_oe = sw_en_ff[p]; // R09
      end else if (osel == `PSR_SW_OUT_IDX || !out_valid(osel)) begin
        route_oe = 1'b0;
      end else if (oe_const1(osel)) begin
        route_oe = 1'b1; // R11
      end else begin
        route_oe = periph_oe[osel[7:0]]; // R10
      end
      slp = mux_cfg_ff[p][`PSR_SLP_SEL_BIT] && light_sleep; // R01 R03
      live_out[p] = route_val ^ route_cfg_ff[p][`PSR_OINV_BIT]; // R16
      live_oe[p]  = slp ? mux_cfg_ff[p][`PSR_SLP_OE_BIT]  : route_oe; // R02
      live_pu[p]  = slp ? mux_cfg_ff[p][`PSR_SLP_WPU_BIT] : mux_cfg_ff[p][`PSR_WPU_BIT]; // R02
      live_pd[p]  = slp ? mux_cfg_ff[p][`PSR_SLP_WPD_BIT] : mux_cfg_ff[p][`PSR_WPD_BIT]; // R02
    end
  end

  // Low-power pads follow their own hold bit; digital pads are also freed by force-release.
  always_comb begin
    for (int p = 0; p < `PSR_PAD_NUM; p++) begin
      if (p < `PSR_LP_PAD_NUM) begin
        held[p] = hold_bits_ff[p]; // R08
      end else begin
        held[p] = hold_bits_ff[p] && !force_release_ff; // R06 R07
      end
    end
  end

  for (genvar g = 0; g < `PSR_PAD_NUM; g++) begin : g_pad
    psr_pad_cell u_cell (
      .clk      (clk),
      .por_rst  (por_rst),
      .hold     (held[g]),
      .live_out (live_out[g]),
      .live_oe  (live_oe[g]),
      .live_pu  (live_pu[g]),
      .live_pd  (live_pd[g]),
      .live_drv (mux_cfg_ff[g][`PSR_DRV_MSB:`PSR_DRV_LSB]),
      .live_in  (pad_in[g]),
      .pad_out  (pad_out[g]),
      .pad_oe   (pad_oe[g]),
      .pad_pu   (pad_pu[g]),
      .pad_pd   (pad_pd[g]),
      .pad_drv  (pad_drv[2*g +: 2]),
      .pad_in_q (pad_in_q[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input routing into the peripherals.

  logic [`PSR_SIG_NUM-1:0] nxt_periph_in;

  always_comb begin
    for (int k = 0; k < `PSR_SIG_NUM; k++) begin
      nxt_periph_in[k] = in_default(8'(k)); // R17
    end
    // Walk from the highest pad down so the lowest-numbered pad wins a shared index.
    for (int p = `PSR_PAD_NUM - 1; p >= 0; p--) begin
      logic [7:0] isel;
      isel = route_cfg_ff[p][`PSR_ISEL_MSB:`PSR_ISEL_LSB];
      if (route_cfg_ff[p][`PSR_IEN_BIT] && in_valid(isel)) begin // R12
        nxt_periph_in[isel] = pad_in_q[p];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int k = 0; k < `PSR_SIG_NUM; k++) begin
        periph_in[k] <= in_default(8'(k)); // R17
      end
    end else begin
      periph_in <= nxt_periph_in;
    end
  end

endmodule
`default_nettype wire

// ### psr_pad_ctrl_asserts.sv
// Concurrent checks on the ports of the pad control block.
`include "psr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module psr_chk (
  input wire logic                      clk,           // System clock.
  input wire logic                      srst,          // Core reset.
  input wire logic                      por_rst,       // Power-on reset.
  input wire logic                      s_axi_awvalid, // Write address valid.
  input wire logic                      s_axi_awready, // Write address ready.
  input wire logic                      s_axi_wvalid,  // Write data valid.
  input wire logic                      s_axi_wready,  // Write data ready.
  input wire logic [1:0]                s_axi_bresp,   // Write response.
  input wire logic                      s_axi_bvalid,  // Write response valid.
  input wire logic                      s_axi_bready,  // Write response ready.
  input wire logic                      s_axi_arvalid, // Read address valid.
  input wire logic                      s_axi_arready, // Read address ready.
  input wire logic [31:0]               s_axi_rdata,   // Read data.
  input wire logic                      s_axi_rvalid,  // Read data valid.
  input wire logic                      s_axi_rready,  // Read data ready.
  input wire logic [`PSR_SIG_NUM-1:0]   periph_in,     // Peripheral inputs.
  input wire logic [`PSR_PAD_NUM-1:0]   pad_out,       // Pad values.
  input wire logic [`PSR_PAD_NUM-1:0]   pad_oe,        // Pad enables.
  input wire logic [`PSR_PAD_NUM-1:0]   pad_pu,        // Pad pull-ups.
  input wire logic [`PSR_PAD_NUM-1:0]   pad_pd,        // Pad pull-downs.
  input wire logic [2*`PSR_PAD_NUM-1:0] pad_drv        // Pad drive strengths.
);
  a_b_stands: assert property (@(posedge clk) disable iff (srst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped early");
  a_r_stands: assert property (@(posedge clk) disable iff (srst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped early");
  a_ar_blocked: assert property (@(posedge clk) disable iff (srst)
    s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while answer pending");
  a_read_answer: assert property (@(posedge clk) disable iff (srst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (@(posedge clk) disable iff (srst)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_in_defaults: assert property (@(posedge clk) srst |=> periph_in[89] && periph_in[116] && !periph_in[0])
    else $error("peripheral input defaults wrong");
  a_in_invalid: assert property (@(posedge clk) disable iff (srst) periph_in[6:4] == 3'h0 && periph_in[50:49] == 2'h0)
    else $error("invalid input index driven");
  a_drv_quiet: assert property (@(posedge clk) disable iff (srst) $changed(pad_drv) |->
    $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3) || $past(srst, 2) || $past(por_rst) || $past(por_rst, 2))
    else $error("drive changed without a write");
  a_por_pads: assert property (@(posedge clk) disable iff (srst) $fell(por_rst) |->
    pad_out == 8'h00 && pad_oe == 8'h00 && pad_pu == 8'h00 && pad_pd == 8'h00 && pad_drv == 16'haaaa)
    else $error("pad state not reset by power-on reset");
endmodule
bind psr_pad_ctrl psr_chk u_chk (.clk(clk), .srst(srst), .por_rst(por_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .periph_in(periph_in), .pad_out(pad_out),
  .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_drv(pad_drv));
`default_nettype wire

// ### psr_far_model.sv
// Model of the peripherals and external pads around the pad control block.
`timescale 1ns/1ps
`default_nettype none
module psr_far_model (
  input  wire logic         flip,       // Inverts the peripheral pattern.
  input  wire logic [7:0]   lvl,        // Levels applied to the pads.
  output logic      [255:0] periph_out, // Peripheral output values.
  output logic      [255:0] periph_oe,  // Peripheral output enables.
  output logic      [7:0]   pad_in      // Pad input levels.
);
  // Each signal carries a pattern of its own index so a wrong route shows up.
  always_comb begin
    pad_in = lvl;
    for (int k = 0; k < 256; k++) begin
      periph_out[k] = k[0] ^ flip;
      periph_oe[k]  = k[1] ^ flip;
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the pad control block.
`include "psr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic         por_rst = 1'b1;
  logic         light_sleep = 1'b0;
  logic         flip = 1'b0;
  logic [7:0]   lvl = 8'h00;
  logic [7:0]   awaddr = 8'h00;
  logic [7:0]   araddr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic         awvalid = 1'b0;
  logic         wvalid = 1'b0;
  logic         bready = 1'b0;
  logic         arvalid = 1'b0;
  logic         rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp;
  logic [31:0]  rdata;
  logic [255:0] periph_out, periph_oe, periph_in;
  logic [7:0]   pad_in, pad_out, pad_oe, pad_pu, pad_pd;
  logic [15:0]  pad_drv;
  int           errors = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  always #20 clk = ~clk;
  psr_far_model far (.flip(flip), .lvl(lvl), .periph_out(periph_out), .periph_oe(periph_oe), .pad_in(pad_in));
  psr_pad_ctrl dut (.clk(clk), .srst(srst), .por_rst(por_rst), .light_sleep(light_sleep),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pad_in(pad_in), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_drv(pad_drv));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awready && !aw) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", 32'(er), 32'(rresp));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int   i;
    logic v, c;
    int   ix[12] = '{0, 12, 40, 54, 59, 89, 90, 187, 188, 210, 229, 252};
    tick(10);
    por_rst <= 1'b0;
    tick(10);
    srst <= 1'b0;
    tick(2);
    chk("in_dflt", 32'h6, 32'({periph_in[116], periph_in[89], periph_in[0]}));
    rd(8'h00, 32'h100, `PSR_RESP_OKAY);
    rd(8'h20, 32'h2, `PSR_RESP_OKAY);
    rd(8'h60, 32'h0, `PSR_RESP_SLVERR);
    wr(8'h60, 32'hff, `PSR_RESP_SLVERR);
    $display("test registers done");
    wr(8'h00, 32'h500, `PSR_RESP_OKAY);
    wr(8'h40, 32'h1, `PSR_RESP_OKAY);
    wr(8'h44, 32'h1, `PSR_RESP_OKAY);
    tick(3);
    chk("pad0_sw", 32'h3, 32'({pad_out[0], pad_oe[0]}));
    wr(8'h44, 32'h0, `PSR_RESP_OKAY);
    tick(3);
    chk("pad0_oe", 32'h0, 32'(pad_oe[0]));
    $display("test software output done");
    for (int k = 0; k < 24; k++) begin
      i = ix[k % 12];
      flip <= (k >= 12);
      wr(8'h04, {22'h0, k[0], i[8:0]}, `PSR_RESP_OKAY);
      tick(3);
      v = (i <= 32) || i == 54 || (i >= 60 && i <= 84) || (i >= 89 && i <= 187) || (i >= 208 && i <= 228);
      c = (i >= 12 && i <= 65) || (i >= 73 && i <= 88) || (i >= 93 && i <= 100) || (i >= 116 && i <= 118);
      chk("pad1_out", 32'((v & (i[0] ^ flip)) ^ k[0]), 32'(pad_out[1]));
      chk("pad1_oe", 32'(v & (c | (i[1] ^ flip))), 32'(pad_oe[1]));
    end
    $display("test routing done");
    wr(8'h28, 32'hd7, `PSR_RESP_OKAY);
    tick(3);
    chk("pad2_run", 32'h13, 32'({pad_pu[2], pad_pd[2], pad_oe[2], pad_drv[5:4]}));
    light_sleep <= 1'b1;
    tick(3);
    chk("pad2_slp", 32'h0f, 32'({pad_pu[2], pad_pd[2], pad_oe[2], pad_drv[5:4]}));
    wr(8'h28, 32'hc7, `PSR_RESP_OKAY);
    tick(3);
    chk("pad2_nosel", 32'h13, 32'({pad_pu[2], pad_pd[2], pad_oe[2], pad_drv[5:4]}));
    light_sleep <= 1'b0;
    $display("test sleep done");
    lvl <= 8'h08;
    wr(8'h0c, 32'h149100, `PSR_RESP_OKAY);
    tick(4);
    chk("in73_hi", 32'h1, 32'(periph_in[73]));
    lvl <= 8'h00;
    tick(4);
    chk("in73_lo", 32'h0, 32'(periph_in[73]));
    wr(8'h0c, 32'h104100, `PSR_RESP_OKAY);
    lvl <= 8'h08;
    tick(4);
    chk("in_unrouted", 32'h0, 32'({periph_in[73], periph_in[4]}));
    $display("test inputs done");
    wr(8'h10, 32'h500, `PSR_RESP_OKAY);
    wr(8'h40, 32'h11, `PSR_RESP_OKAY);
    wr(8'h44, 32'h11, `PSR_RESP_OKAY);
    wr(8'h4c, 32'h0, `PSR_RESP_OKAY);
    wr(8'h48, 32'h11, `PSR_RESP_OKAY);
    wr(8'h40, 32'h0, `PSR_RESP_OKAY);
    tick(3);
    chk("held", 32'h3, 32'({pad_out[4], pad_out[0]}));
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    tick(3);
    chk("held_rst", 32'h3, 32'({pad_out[4], pad_out[0]}));
    wr(8'h4c, 32'h1, `PSR_RESP_OKAY);
    tick(3);
    chk("released", 32'h1, 32'({pad_out[4], pad_out[0]}));
    wr(8'h48, 32'h0, `PSR_RESP_OKAY);
    tick(3);
    chk("lp_release", 32'h0, 32'(pad_out[0]));
    wr(8'h48, 32'h3, `PSR_RESP_OKAY);
    por_rst <= 1'b1;
    tick(2);
    por_rst <= 1'b0;
    rd(8'h48, 32'h0, `PSR_RESP_OKAY);
    $display("test hold done");
    complete_run;
  end
endmodule
`default_nettype wire
